// ### rtl/qwts_consts.svh
// constants for the quad wiper two-wire slave: encodings, field positions,
// reset values and timing figures; assumes a 125 MHz core clock
`ifndef QWTS_CONSTS_SVH
`define QWTS_CONSTS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define QWTS_CLK_MHZ 125
`define QWTS_T_WR_US 5000
`define QWTS_WR_CNT_W 20

// ------------------------------------------------------------
// address, instruction and data byte fields
// ------------------------------------------------------------
`define QWTS_OP_FIELD 7:4
`define QWTS_POT_FIELD 3:2
`define QWTS_SEL_FIELD 1:0
`define QWTS_TYPE_FIELD 7:4
`define QWTS_STRAP_FIELD 3:0
`define QWTS_POS_FIELD 5:0

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define QWTS_OP_READ_WCR 4'h9
`define QWTS_OP_WRITE_WCR 4'hA
`define QWTS_OP_READ_DR 4'hB
`define QWTS_OP_WRITE_DR 4'hC
`define QWTS_OP_XFR_DR_WCR 4'hD
`define QWTS_OP_XFR_WCR_DR 4'hE
`define QWTS_OP_GXFR_DR_WCR 4'h1
`define QWTS_OP_GXFR_WCR_DR 4'h8
`define QWTS_OP_INCDEC 4'h2

// ------------------------------------------------------------
// reset values and position limits
// ------------------------------------------------------------
`define QWTS_PIN_RESET 6'h30
`define QWTS_WIPER_RESET 6'h00
`define QWTS_STORED_RESET 6'h20
`define QWTS_TAP_RESET 64'h0000_0000_0000_0001
`define QWTS_POS_MAX 6'h3F
`define QWTS_POS_MIN 6'h00

`endif

// ### rtl/qwts_pkg.sv
// types shared by the quad wiper two-wire slave
// assumes qwts_consts.svh supplies the numeric constants
package qwts_pkg;
  typedef enum logic [2:0] {QWTS_IDLE, QWTS_ADDR, QWTS_INSTR, QWTS_DATA_RX, QWTS_DATA_TX, QWTS_INCDEC,
    QWTS_IGNORE} qwts_state_t;
  typedef logic [5:0] qwts_pos_t;
  typedef logic [63:0] qwts_tap_t;
endpackage

// ### rtl/qwts_sync.sv
// two-flop level synchroniser for pins entering the core clock domain
// assumes the inputs are quasi-static compared with the core clock
`timescale 1ns/100ps
module qwts_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// ### rtl/qwts_link_capture.sv
// serial-clock domain: samples the data line on each rising serial clock
// assumes the core domain reads the held bit only after it has seen the
// synchronised rising clock, so the bit is stable for the whole read
`timescale 1ns/100ps
module qwts_link_capture (
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic bit_val
);
  logic bit_reg;

  // no reset: the serial clock may be still, and the core never reads this
  // flop before a clock edge has qualified it
  always_ff @(posedge scl_clk)
  begin
    bit_reg <= sda_i;
  end

  assign bit_val = bit_reg;
endmodule

// ### rtl/qwts_slave.sv
// quad wiper two-wire slave: bus protocol, wiper and stored positions, taps
// assumes an external pull-up on the data line and a master driving the clock
`timescale 1ns/100ps
`include "qwts_consts.svh"
module qwts_slave #(
  parameter int WRITE_CYCLES = `QWTS_T_WR_US * `QWTS_CLK_MHZ,
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h3 // value arbitrary
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [3:0] device_select_straps,
  output qwts_pkg::qwts_tap_t [3:0] tap_enable,
  output logic write_busy
);
  import qwts_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic qwts_tap_t tap_decode(input qwts_pos_t pos);
    return qwts_tap_t'(`QWTS_TAP_RESET) << pos;
  endfunction

  function automatic logic op_valid(input logic [3:0] op);
    case (op)
      `QWTS_OP_READ_WCR, `QWTS_OP_WRITE_WCR, `QWTS_OP_READ_DR, `QWTS_OP_WRITE_DR,
      `QWTS_OP_XFR_DR_WCR, `QWTS_OP_XFR_WCR_DR, `QWTS_OP_GXFR_DR_WCR,
      `QWTS_OP_GXFR_WCR_DR, `QWTS_OP_INCDEC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pin sampling and bus conditions
  // ------------------------------------------------------------
  logic [5:0] pins_sync;
  logic scl_s, sda_s, link_bit;
  logic [3:0] straps_s;
  logic scl_prev_reg, sda_prev_reg;
  logic start_det, stop_det, scl_rise, scl_fall;

  qwts_sync #(.WIDTH(6), .RESET_VAL(`QWTS_PIN_RESET)) u_pin_sync (
    .clk(core_clk),
    .nrst(nrst),
    .din({scl, sda_i, device_select_straps}),
    .dout(pins_sync)
  );

  qwts_link_capture u_link (
    .scl_clk(scl),
    .sda_i(sda_i),
    .bit_val(link_bit)
  );

  assign scl_s = pins_sync[5];
  assign sda_s = pins_sync[4];
  assign straps_s = pins_sync[3:0];

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // data moving while clock is high is a condition, never a bit
  assign start_det = scl_prev_reg & scl_s & sda_prev_reg & ~sda_s;
  assign stop_det = scl_prev_reg & scl_s & ~sda_prev_reg & sda_s;
  // bits are taken only on master clock edges
  assign scl_rise = ~scl_prev_reg & scl_s;
  assign scl_fall = scl_prev_reg & ~scl_s;

  // ------------------------------------------------------------
  // byte framing
  // ------------------------------------------------------------
  qwts_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg, rx_byte;
  logic [3:0] op_reg;
  logic [1:0] pot_reg, sel_reg;
  logic busy_reg, addr_match, byte_end, instr_end, data_end, step_evt;
  qwts_pos_t wiper_reg [4];
  qwts_pos_t stored_reg [4][4];

  assign rx_byte = {shift_reg[6:0], link_bit};
  assign byte_end = scl_rise && bitcnt_reg == 4'd7;
  assign addr_match = rx_byte[`QWTS_TYPE_FIELD] == DEVICE_TYPE_ID
    && rx_byte[`QWTS_STRAP_FIELD] == straps_s;
  assign instr_end = byte_end && state_reg == QWTS_INSTR;
  assign data_end = byte_end && state_reg == QWTS_DATA_RX;
  assign step_evt = scl_rise && state_reg == QWTS_INCDEC && bitcnt_reg != 4'd8;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      shift_reg <= 8'h00;
    else if (scl_rise)
      shift_reg <= rx_byte;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_reg <= QWTS_IDLE;
      bitcnt_reg <= 4'd0;
    end
    else if (start_det)
    begin
      state_reg <= QWTS_ADDR;
      bitcnt_reg <= 4'd0;
    end
    else if (stop_det)
      state_reg <= QWTS_IDLE;
    else if (scl_rise && state_reg != QWTS_IDLE)
    begin
      if (bitcnt_reg == 4'd8)
        bitcnt_reg <= 4'd0;
      else
      begin
        case (state_reg)
          QWTS_ADDR:
          begin
            bitcnt_reg <= bitcnt_reg + 4'd1;
            // mismatch or busy: stay silent until the next start
            if (bitcnt_reg == 4'd7)
              state_reg <= (addr_match && !busy_reg) ? QWTS_INSTR : QWTS_IGNORE;
          end
          QWTS_INSTR:
          begin
            bitcnt_reg <= bitcnt_reg + 4'd1;
            if (bitcnt_reg == 4'd7)
            begin
              case (rx_byte[`QWTS_OP_FIELD])
                `QWTS_OP_READ_WCR, `QWTS_OP_READ_DR: state_reg <= QWTS_DATA_TX;
                `QWTS_OP_WRITE_WCR, `QWTS_OP_WRITE_DR: state_reg <= QWTS_DATA_RX;
                `QWTS_OP_INCDEC: state_reg <= QWTS_INCDEC;
                default: state_reg <= QWTS_IGNORE;
              endcase
            end
          end
          QWTS_DATA_RX, QWTS_DATA_TX:
          begin
            bitcnt_reg <= bitcnt_reg + 4'd1;
            if (bitcnt_reg == 4'd7)
              state_reg <= QWTS_IGNORE;
          end
          default:
            bitcnt_reg <= bitcnt_reg;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      op_reg <= 4'h0;
      pot_reg <= 2'd0;
      sel_reg <= 2'd0;
    end
    else if (instr_end)
    begin
      op_reg <= rx_byte[`QWTS_OP_FIELD];
      pot_reg <= rx_byte[`QWTS_POT_FIELD];
      sel_reg <= rx_byte[`QWTS_SEL_FIELD];
    end
  end

  // ------------------------------------------------------------
  // acknowledge and transmit on the data line
  // ------------------------------------------------------------
  logic ack_req_reg, sda_oe_n_reg, sda_o_reg, tx_active_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_cnt_reg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst || start_det || stop_det)
      ack_req_reg <= 1'b0;
    else if (byte_end && ((state_reg == QWTS_ADDR && addr_match && !busy_reg)
      || (state_reg == QWTS_INSTR && op_valid(rx_byte[`QWTS_OP_FIELD]))
      || state_reg == QWTS_DATA_RX))
      ack_req_reg <= 1'b1;
    else if (scl_fall)
      ack_req_reg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || start_det || stop_det)
    begin
      tx_active_reg <= 1'b0;
      tx_cnt_reg <= 4'd0;
      tx_shift_reg <= 8'h00;
    end
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_READ_WCR)
    begin
      tx_active_reg <= 1'b1;
      tx_cnt_reg <= 4'd0;
      tx_shift_reg <= {2'b00, wiper_reg[rx_byte[`QWTS_POT_FIELD]]};
    end
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_READ_DR)
    begin
      tx_active_reg <= 1'b1;
      tx_cnt_reg <= 4'd0;
      tx_shift_reg <= {2'b00, stored_reg[rx_byte[`QWTS_POT_FIELD]][rx_byte[`QWTS_SEL_FIELD]]};
    end
    else if (scl_fall && !ack_req_reg && tx_active_reg && tx_cnt_reg != 4'd8)
    begin
      tx_cnt_reg <= tx_cnt_reg + 4'd1;
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  // changes only on falling clock, so data is steady while clock is high
  always_ff @(posedge core_clk)
  begin
    if (!nrst || start_det || stop_det)
      sda_oe_n_reg <= 1'b1;
    else if (scl_fall)
    begin
      if (ack_req_reg)
        sda_oe_n_reg <= 1'b0;
      else if (tx_active_reg && tx_cnt_reg != 4'd8)
        sda_oe_n_reg <= tx_shift_reg[7];
      else
        sda_oe_n_reg <= 1'b1; // release for the master's ack slot
    end
  end

  // the level driven is always low; only the enable moves
  always_ff @(posedge core_clk)
  begin
    sda_o_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // wiper and stored positions
  // ------------------------------------------------------------
  logic nv_pending_reg, recall_reg;
  logic [`QWTS_WR_CNT_W-1:0] wr_cnt_reg;
  qwts_tap_t tap_reg [4];

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      recall_reg <= 1'b1;
    else
      recall_reg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
        wiper_reg[i] <= `QWTS_WIPER_RESET;
    end
    else if (recall_reg)
    begin
      for (int i = 0; i < 4; i++)
        wiper_reg[i] <= stored_reg[i][0];
    end
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_XFR_DR_WCR)
      wiper_reg[rx_byte[`QWTS_POT_FIELD]] <= stored_reg[rx_byte[`QWTS_POT_FIELD]][rx_byte[`QWTS_SEL_FIELD]];
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_GXFR_DR_WCR)
    begin
      for (int i = 0; i < 4; i++)
        wiper_reg[i] <= stored_reg[i][rx_byte[`QWTS_SEL_FIELD]];
    end
    else if (data_end && op_reg == `QWTS_OP_WRITE_WCR)
      wiper_reg[pot_reg] <= rx_byte[`QWTS_POS_FIELD];
    else if (step_evt)
    begin
      // saturate at the array ends rather than wrap to the far terminal
      if (link_bit && wiper_reg[pot_reg] != `QWTS_POS_MAX)
        wiper_reg[pot_reg] <= wiper_reg[pot_reg] + 6'd1;
      else if (!link_bit && wiper_reg[pot_reg] != `QWTS_POS_MIN)
        wiper_reg[pot_reg] <= wiper_reg[pot_reg] - 6'd1;
    end
  end

  // stored slots are flops standing in for the nonvolatile array
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
        for (int j = 0; j < 4; j++)
          stored_reg[i][j] <= `QWTS_STORED_RESET;
    end
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_XFR_WCR_DR)
      stored_reg[rx_byte[`QWTS_POT_FIELD]][rx_byte[`QWTS_SEL_FIELD]] <= wiper_reg[rx_byte[`QWTS_POT_FIELD]];
    else if (instr_end && rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_GXFR_WCR_DR)
    begin
      for (int i = 0; i < 4; i++)
        stored_reg[i][rx_byte[`QWTS_SEL_FIELD]] <= wiper_reg[i];
    end
    else if (data_end && op_reg == `QWTS_OP_WRITE_DR)
      stored_reg[pot_reg][sel_reg] <= rx_byte[`QWTS_POS_FIELD];
  end

  // ------------------------------------------------------------
  // store write busy period
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst || stop_det)
      nv_pending_reg <= 1'b0;
    else if ((instr_end && (rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_XFR_WCR_DR
      || rx_byte[`QWTS_OP_FIELD] == `QWTS_OP_GXFR_WCR_DR))
      || (data_end && op_reg == `QWTS_OP_WRITE_DR))
      nv_pending_reg <= 1'b1;
  end

  // polling masters see no ack until this ends
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      busy_reg <= 1'b0;
      wr_cnt_reg <= '0;
    end
    else if (stop_det && nv_pending_reg)
    begin
      busy_reg <= 1'b1;
      wr_cnt_reg <= '0;
    end
    else if (busy_reg)
    begin
      if (wr_cnt_reg == `QWTS_WR_CNT_W'(WRITE_CYCLES - 1))
        busy_reg <= 1'b0;
      else
        wr_cnt_reg <= wr_cnt_reg + `QWTS_WR_CNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // tap selection
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 4; i++)
      tap_reg[i] <= !nrst ? `QWTS_TAP_RESET : tap_decode(wiper_reg[i]);
  end

  assign sda_o = sda_o_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign write_busy = busy_reg;
  assign tap_enable = {tap_reg[3], tap_reg[2], tap_reg[1], tap_reg[0]};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_start_to_addr: assert property (start_det |=> state_reg == QWTS_ADDR && bitcnt_reg == 4'd0)
    else $error("start did not open address phase");
  a_stop_to_idle: assert property (stop_det |=> state_reg == QWTS_IDLE && sda_oe_n_reg)
    else $error("stop did not end transaction");
  a_sda_never_high: assert property (!sda_o_reg)
    else $error("data line driven high");
  a_ack_on_fall: assert property (ack_req_reg && scl_fall |=> !sda_oe_n_reg)
    else $error("ack not driven in ninth clock");
  a_addr_ack_match: assert property (byte_end && state_reg == QWTS_ADDR && addr_match && !busy_reg
    |=> ack_req_reg && state_reg == QWTS_INSTR)
    else $error("matching address not acknowledged");
  a_busy_no_ack: assert property (byte_end && state_reg == QWTS_ADDR && busy_reg
    |=> !ack_req_reg && state_reg == QWTS_IGNORE)
    else $error("address acked while busy");
  a_mismatch_quiet: assert property (byte_end && state_reg == QWTS_ADDR && !addr_match
    |=> sda_oe_n_reg [*8])
    else $error("data line pulled after mismatch");
  a_busy_start: assert property (stop_det && nv_pending_reg |=> busy_reg && wr_cnt_reg == '0)
    else $error("store write did not start busy");
  a_busy_length: assert property ($fell(busy_reg) |-> $past(wr_cnt_reg) == `QWTS_WR_CNT_W'(WRITE_CYCLES - 1))
    else $error("busy period wrong length");
  a_tap_onehot: assert property ($onehot(tap_reg[0]) && $onehot(tap_reg[1])
    && $onehot(tap_reg[2]) && $onehot(tap_reg[3]))
    else $error("tap selection not one-hot");
  a_tap_follows: assert property (##2 tap_reg[1] == tap_decode($past(wiper_reg[1])))
    else $error("tap does not follow wiper");
  a_recall_slot0: assert property (recall_reg |=> wiper_reg[2] == $past(stored_reg[2][0]))
    else $error("wiper not recalled from slot zero");
  a_other_pot_kept: assert property (data_end && op_reg == `QWTS_OP_WRITE_WCR && pot_reg != 2'd0
    |=> $stable(wiper_reg[0]))
    else $error("other wiper changed");
  a_step_up: assert property (step_evt && link_bit && wiper_reg[pot_reg] != `QWTS_POS_MAX
    |=> wiper_reg[pot_reg] == $past(wiper_reg[pot_reg]) + 6'd1)
    else $error("increment step missing");
  a_step_down: assert property (step_evt && !link_bit && wiper_reg[pot_reg] != `QWTS_POS_MIN
    |=> wiper_reg[pot_reg] == $past(wiper_reg[pot_reg]) - 6'd1)
    else $error("decrement step missing");

  c_addr_ack: cover property (byte_end && state_reg == QWTS_ADDR && addr_match && !busy_reg);
  c_read_tx: cover property (tx_active_reg && tx_cnt_reg == 4'd8);
  c_step: cover property (step_evt);
  c_busy_poll: cover property (byte_end && state_reg == QWTS_ADDR && busy_reg);
endmodule

// ### verif/qwts_master.sv
// two-wire bus master model: drives the serial clock, shares the data line
// assumes the slave pulls the line low only while its enable is low
`timescale 1ns/100ps
module qwts_master #(
  parameter int T_Q = 47
) (
  output logic scl,
  output logic sda,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  logic sda_m;
  // pull-up: a released line reads high, any low driver wins
  assign sda = sda_m & (sda_oe_n | sda_o);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // clock stands high between frames
  task automatic start();
    sda_m = 1'b0;
    #T_Q;
    scl = 1'b0;
    #T_Q;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #T_Q;
    scl = 1'b1;
    #T_Q;
    sda_m = 1'b1;
    #T_Q;
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_m = b;
    #T_Q;
    scl = 1'b1;
    #T_Q;
    r = sda;
    #T_Q;
    scl = 1'b0;
    #T_Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      d[i] = r;
    end
    // no ack from the master ends the read
    xbit(1'b1, r);
  endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the quad wiper two-wire slave
// assumes qwts_master models the bus master on the serial side
`timescale 1ns/100ps
module tb_top;
  import qwts_pkg::*;
  localparam logic [3:0] TYPE_ID = 4'h3; // value arbitrary
  localparam int WR_CYC = 2000;
  logic core_clk, nrst, scl, sda, sda_o, sda_oe_n, write_busy, a;
  logic [3:0] straps;
  logic [7:0] d;
  qwts_tap_t [3:0] tap_enable;
  int failures, n_tests, cyc, n;
  qwts_slave #(.WRITE_CYCLES(WR_CYC), .DEVICE_TYPE_ID(TYPE_ID)) dut_u (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .device_select_straps(straps),
    .tap_enable(tap_enable),
    .write_busy(write_busy)
  );
  qwts_master m_u (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] ins);
    m_u.start();
    m_u.wbyte({TYPE_ID, straps}, a);
    chk(a, 1);
    m_u.wbyte(ins, a);
    chk(a, 1);
  endtask
  task automatic taps(input logic [5:0] p0, p1, p2, p3);
    idle(8);
    chk(tap_enable[0], 64'h1 << p0);
    chk(tap_enable[1], 64'h1 << p1);
    chk(tap_enable[2], 64'h1 << p2);
    chk(tap_enable[3], 64'h1 << p3);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(write_busy, 0);
    chk(sda_oe_n, 1);
    chk(sda_o, 0);
    taps(6'h20, 6'h20, 6'h20, 6'h20);
  endtask
  task automatic t_addr();
    m_u.start();
    m_u.wbyte({TYPE_ID, straps ^ 4'h1}, a);
    chk(a, 0);
    m_u.wbyte(8'hA4, a);
    chk(a, 0);
    m_u.stop();
    m_u.start();
    m_u.wbyte({4'h7, straps}, a);
    chk(a, 0);
    m_u.stop();
    idle(1);
    straps = 4'h6;
    idle(8);
    cmd(8'h9C);
    m_u.rbyte(d);
    m_u.stop();
    chk(d, 8'h20);
  endtask
  task automatic t_write();
    cmd(8'hA4);
    // only the low six bits reach the wiper
    m_u.wbyte(8'hD5, a);
    chk(a, 1);
    m_u.stop();
    taps(6'h20, 6'h15, 6'h20, 6'h20);
    cmd(8'h94);
    m_u.rbyte(d);
    m_u.stop();
    chk(d, 8'h15);
  endtask
  task automatic t_store();
    cmd(8'hCB);
    m_u.wbyte(8'h3F, a);
    chk(a, 1);
    m_u.stop();
    idle(2);
    chk(write_busy, 1);
    m_u.start();
    m_u.wbyte({TYPE_ID, straps}, a);
    chk(a, 0);
    m_u.stop();
    n = 0;
    while (a !== 1'b1 && n < 40)
    begin
      m_u.start();
      m_u.wbyte({TYPE_ID, straps}, a);
      n++;
      if (a !== 1'b1)
      begin
        m_u.stop();
      end
    end
    chk(a, 1);
    chk(write_busy, 0);
    m_u.wbyte(8'hDB, a);
    chk(a, 1);
    m_u.stop();
    taps(6'h20, 6'h15, 6'h3F, 6'h20);
    cmd(8'hBB);
    m_u.rbyte(d);
    m_u.stop();
    chk(d, 8'h3F);
  endtask
  task automatic t_incdec();
    logic r;
    cmd(8'h20);
    m_u.xbit(1'b1, r);
    m_u.xbit(1'b1, r);
    m_u.xbit(1'b1, r);
    m_u.xbit(1'b0, r);
    // the clock rise ahead of the stop steps down once more
    m_u.stop();
    taps(6'h21, 6'h15, 6'h3F, 6'h20);
  endtask
  task automatic t_global();
    // single and global wiper-to-store copies both launch a busy period
    cmd(8'hE6);
    m_u.stop();
    idle(2);
    chk(write_busy, 1);
    idle(WR_CYC);
    chk(write_busy, 0);
    cmd(8'h81);
    m_u.stop();
    idle(WR_CYC + 2);
    cmd(8'h10);
    m_u.stop();
    taps(6'h20, 6'h20, 6'h20, 6'h20);
    cmd(8'h11);
    m_u.stop();
    taps(6'h21, 6'h15, 6'h3F, 6'h20);
    cmd(8'hB6);
    m_u.rbyte(d);
    m_u.stop();
    chk(d, 8'h15);
  endtask
  initial
  begin
    nrst = 1'b0;
    straps = 4'hA;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    // two edges: every reset branch loads constants, synchronisers included
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    idle(6);
    t_reset();
    t_addr();
    t_write();
    t_store();
    t_incdec();
    t_global();
    end_of_test();
  end
endmodule
